// [alarm_latch_accept_unit.sv]
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module alarm_latch_accept_unit (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Wishbone slave
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [alarm_latch_pkg::ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [alarm_latch_pkg::DATA_W-1:0] WB_DAT_I,
    output logic [alarm_latch_pkg::DATA_W-1:0] WB_DAT_O,
    output logic WB_ACK_O,
    // Field unit sources
    input wire alarm_latch_pkg::field_in_t FIELD_IN,
    // Command toward the loop
    output alarm_latch_pkg::cmd_t LOOP_CMD
);
    import alarm_latch_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    field_in_t sync1;
    field_in_t sync2;
    logic [N_UNITS-1:0][GRP_W-1:0] prev_src;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sync1 <= '0;
            sync2 <= '0;
            prev_src <= '0;
        end else begin
            sync1 <= FIELD_IN;
            sync2 <= sync1;
            prev_src <= sync2.alarm;
        end
    end

    logic [N_UNITS-1:0] live;
    logic [N_UNITS-1:0] rise;

    always_comb begin
        for (int u = 0; u < N_UNITS; u++) begin
            live[u] = |sync2.alarm[u]; // [RULE11]
            rise[u] = |(sync2.alarm[u] & ~prev_src[u]);
        end
    end

    // ****************************************
    // Bus decode
    // ****************************************
    logic [REGION_W-1:0] region;
    db_idx_t db;
    logic [IDX_W-1:0] idx;
    unit_idx_t unit;
    unit_idx_t disc_unit;
    logic unit_ok;
    logic disc_ok;
    logic db_ok;
    logic access;
    logic done;
    logic wr_ok;
    logic rd_done;

    always_comb begin
        // Link addresses are used as given, counting from zero
        region = adr_region(WB_ADR_I); // [RULE20]
        db = adr_db(WB_ADR_I);
        idx = adr_idx(WB_ADR_I);
        unit = idx[UNIT_W-1:0];
        disc_unit = idx[IDX_W-1:DISC_BIT_W]; // [RULE2]
        unit_ok = (idx < IDX_W'(N_UNITS));
        disc_ok = (disc_unit < UNIT_W'(N_UNITS));
        db_ok = (db < DB_W'(N_DB));
        access = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
        done = WB_CYC_I & WB_STB_I & WB_ACK_O;
        // Writes that leave out either low byte would split an accept or a command, so they are ignored
        wr_ok = done & WB_WE_I & (WB_SEL_I[1:0] == SEL_LOW_HALF);
        rd_done = done & ~WB_WE_I;
    end

    // ****************************************
    // Control and accept
    // ****************************************
    logic [CTRL_W-1:0] ctrl;
    logic [CTRL_W-1:0] next_ctrl;
    logic [GRP_W-1:0] loopback;
    logic [GRP_W-1:0] next_loopback;
    logic [N_DB-1:0] accept;
    logic station_wr;

    always_comb begin
        station_wr = wr_ok & (region == REG_STATION) & db_ok;
        next_ctrl = ctrl;
        next_loopback = loopback;
        if (station_wr && idx == IDX_CTRL) begin
            next_ctrl = WB_DAT_I[CTRL_W-1:0];
        end
        if (station_wr && idx == IDX_LOOPBACK) begin
            next_loopback = WB_DAT_I[GRP_W-1:0]; // [RULE19]
        end
        for (int d = 0; d < N_DB; d++) begin
            accept[d] = station_wr && (idx == IDX_ACCEPT) && (db == DB_W'(d)); // [RULE6] [RULE7]
            // Linking joins the serial databases only; the network database stays apart
            if (station_wr && idx == IDX_ACCEPT && ctrl[CTRL_LINK_BIT] &&
                d < N_SERIAL && db < DB_W'(N_SERIAL)) begin
                accept[d] = 1'b1; // [RULE6]
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ctrl <= CTRL_RESET;
            loopback <= '0;
        end else begin
            ctrl <= next_ctrl;
            loopback <= next_loopback;
        end
    end

    // ****************************************
    // Alarm latches, one set per database
    // ****************************************
    wire [GRP_W-1:0] latch_w [N_DB][N_UNITS];
    wire [N_UNITS-1:0] sum_w [N_DB];
    wire [N_UNITS-1:0] new_w [N_DB];

    for (genvar d = 0; d < N_DB; d++) begin : g_db
        for (genvar u = 0; u < N_UNITS; u++) begin : g_unit
            latch_t grp;
            latch_t next_grp;
            latch_t sum;
            latch_t next_sum;
            logic newf;
            logic next_newf;
            logic [GRP_W-1:0] seen;
            logic [GRP_W-1:0] sum_seen;
            logic here;

            always_comb begin
                seen = '0;
                sum_seen = '0;
                here = rd_done && (db == DB_W'(d));
                // Markers follow the data actually returned, not the live latch
                if (here && region == REG_ALARM && idx == IDX_W'(u)) begin
                    seen = WB_DAT_O[GRP_W-1:0]; // [RULE21]
                end
                if (here && region == REG_DISC && disc_unit == UNIT_W'(u)) begin
                    seen = GRP_W'(WB_DAT_O[0]) << idx[DISC_BIT_W-1:0]; // [RULE2] [RULE21]
                end
                if (here && region == REG_USTAT && idx == IDX_W'(u)) begin
                    sum_seen[0] = WB_DAT_O[USTAT_SUMMARY_BIT];
                end
                next_grp = latch_step(grp, sync2.alarm[u], seen, accept[d]); // [RULE8] [RULE9]
                next_sum = latch_step(sum, GRP_W'(live[u]), sum_seen, accept[d]); // [RULE12]
                next_newf = rise[u] | (newf & ~accept[d]); // [RULE13]
            end

            always_ff @(posedge CLK) begin
                if (!RST_N) begin
                    grp <= '0;
                    sum <= '0;
                    newf <= 1'b0;
                end else begin
                    grp <= next_grp;
                    sum <= next_sum;
                    newf <= next_newf;
                end
            end

            assign latch_w[d][u] = grp.latch;
            assign sum_w[d][u] = sum.latch[0];
            assign new_w[d][u] = newf;
        end
    end

    // ****************************************
    // Station common alarms
    // ****************************************
    logic [GRP_W-1:0] station_status [N_DB];

    always_comb begin
        for (int d = 0; d < N_DB; d++) begin
            station_status[d] = '0;
            station_status[d][STAT_COMMON_UNIT_BIT] = |(sum_w[d] | sync2.offline); // [RULE14] [RULE15]
            station_status[d][STAT_COMMON_RELAY_BIT] = |sync2.relay; // [RULE16]
        end
    end

    // ****************************************
    // Holding registers
    // ****************************************
    logic [GRP_W-1:0] hold_loop [N_DB][N_UNITS];
    logic [GRP_W-1:0] hold_sel;
    logic [GRP_W-1:0] conv_loop;
    logic [GRP_W-1:0] conv_rb;
    logic out_wr;
    cmd_t next_cmd;

    always_comb begin
        hold_sel = (db_ok && unit_ok) ? hold_loop[db][unit] : '0;
        out_wr = wr_ok & ((region == REG_HOLD) | (region == REG_COIL)) & db_ok & unit_ok;
        next_cmd = '0;
        if (out_wr) begin
            next_cmd.valid = 1'b1;
            next_cmd.db = db;
            next_cmd.unit = unit;
            next_cmd.data = conv_loop;
        end
    end

    output_value_conv u_conv (
        .wr_data(WB_DAT_I[GRP_W-1:0]),
        .is_coil(region == REG_COIL),
        .alt_variant(ctrl[CTRL_VARIANT_BIT]),
        .loop_in(hold_sel),
        .loop_out(conv_loop),
        .readback(conv_rb)
    );

    // The array is data, not control; it is still cleared so readback is defined
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            for (int d = 0; d < N_DB; d++) begin
                for (int u = 0; u < N_UNITS; u++) begin
                    hold_loop[d][u] <= '0;
                end
            end
        end else if (out_wr) begin
            hold_loop[db][unit] <= conv_loop; // [RULE5]
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            LOOP_CMD <= '0;
        end else begin
            LOOP_CMD <= next_cmd;
        end
    end

    // ****************************************
    // Read data and acknowledge
    // ****************************************
    logic [GRP_W-1:0] rd_value;
    logic [DATA_W-1:0] next_dat;
    logic next_ack;

    always_comb begin
        rd_value = '0;
        if (db_ok) begin
            case (region)
                REG_STATION: begin
                    if (idx == IDX_CTRL) begin
                        rd_value = GRP_W'(ctrl);
                    end else if (idx == IDX_STATUS) begin
                        rd_value = station_status[db];
                    end else if (idx == IDX_LOOPBACK) begin
                        rd_value = loopback; // [RULE19]
                    end
                end
                REG_ALARM: begin
                    if (unit_ok) begin
                        rd_value = latch_w[db][unit];
                    end
                end
                REG_USTAT: begin
                    if (unit_ok) begin
                        rd_value[USTAT_SUMMARY_BIT] = sum_w[db][unit];
                        rd_value[USTAT_NEW_BIT] = new_w[db][unit];
                        rd_value[USTAT_LIVE_BIT] = live[unit]; // [RULE11]
                    end
                end
                REG_DISC: begin
                    if (disc_ok) begin
                        rd_value[0] = latch_w[db][disc_unit][idx[DISC_BIT_W-1:0]]; // [RULE2]
                    end
                end
                REG_HOLD, REG_COIL: begin
                    if (unit_ok) begin
                        rd_value = conv_rb; // [RULE4]
                    end
                end
                default: begin
                    rd_value = '0;
                end
            endcase
        end
        next_ack = access;
        next_dat = access ? DATA_W'(rd_value) : WB_DAT_O;
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end else begin
            WB_ACK_O <= next_ack;
            WB_DAT_O <= next_dat;
        end
    end
endmodule

// [alarm_latch_pkg.sv]
// Overview of operation
// RULE1: Host may add a per-function offset; only the raw address crosses the link.
// RULE2: A discrete address is sixteen times its register address, one bit each.
// RULE3: Coil write data zero turns off; any nonzero data turns on.
// RULE4: Holding readback is 16-bit two's complement, capped per protocol variant.
// RULE5: Holding readback derives from the value sent to the unit, may differ by one.
// RULE6: Each serial port keeps its own alarm latches unless linking is enabled.
// RULE7: Both network ports share one database separate from the serial ports.
// RULE8: Sixteen alarm bits per unit latch as soon as their source asserts.
// RULE9: A latched bit clears only after read, then accept, then source normal.
// RULE10: Accept does not clear an unread bit; it stays set indefinitely.
// RULE11: Per-unit summary alarm is the OR of sources ahead of their latches.
// RULE12: Summary alarm latches and clears after read, accept and source normal.
// RULE13: New-alarm flag sets on any new alarm; every accept clears it.
// RULE14: Station status bit 2 is set while any unit summary alarm is set.
// RULE15: An offline unit counts as alarmed in the common unit alarm.
// RULE16: Station status bit 3 is the common alarm of monitor-relay sources.
// RULE17: Host accepts alarms by writing station parameter 5 after reading them.
// RULE18: Host scans alarms, digital, accept if new, then analogue status.
// RULE19: The diagnostic loopback function is supported but optional for the host.
// RULE20: Link addresses are zero-based; one-based hosts subtract one.
// RULE21: A read sets per-bit markers; accept turns them into accepted state.
package alarm_latch_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int N_UNITS = 60;
    localparam int N_DB = 3;
    localparam int N_SERIAL = 2;
    localparam int GRP_W = 16;
    localparam int DATA_W = 32;
    localparam int ADR_W = 18;
    localparam int UNIT_W = 6;
    localparam int DB_W = 2;
    localparam int IDX_W = 10;
    localparam int REGION_W = 4;
    localparam int DISC_BIT_W = 4;

    // ****************************************
    // Address fields and regions
    // ****************************************
    localparam int ADR_REGION_LO = 14;
    localparam int ADR_DB_LO = 12;
    localparam int ADR_IDX_LO = 2;
    localparam logic [REGION_W-1:0] REG_STATION = 4'h0;
    localparam logic [REGION_W-1:0] REG_ALARM = 4'h1;
    localparam logic [REGION_W-1:0] REG_USTAT = 4'h2;
    localparam logic [REGION_W-1:0] REG_DISC = 4'h3;
    localparam logic [REGION_W-1:0] REG_HOLD = 4'h4;
    localparam logic [REGION_W-1:0] REG_COIL = 4'h5;
    localparam logic [IDX_W-1:0] IDX_CTRL = 10'h000;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h001;
    localparam logic [IDX_W-1:0] IDX_LOOPBACK = 10'h002;
    localparam logic [IDX_W-1:0] IDX_ACCEPT = 10'h005;

    // ****************************************
    // Field positions and values
    // ****************************************
    localparam int CTRL_LINK_BIT = 0;
    localparam int CTRL_VARIANT_BIT = 1;
    localparam int CTRL_W = 2;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
    localparam int STAT_COMMON_UNIT_BIT = 2;
    localparam int STAT_COMMON_RELAY_BIT = 3;
    localparam int USTAT_SUMMARY_BIT = 0;
    localparam int USTAT_NEW_BIT = 1;
    localparam int USTAT_LIVE_BIT = 2;
    localparam logic [GRP_W-1:0] COIL_OFF = 16'h0000;
    localparam logic [GRP_W-1:0] HOLD_MAX_GENERIC = 16'h7FFF;
    localparam logic [GRP_W-1:0] HOLD_MAX_ALT = 16'h0FFF;
    localparam int LOOP_SHIFT_GENERIC = 1;
    localparam int LOOP_SHIFT_ALT = 0;
    localparam logic [1:0] SEL_LOW_HALF = 2'h3;

    // ****************************************
    // Types
    // ****************************************
    typedef logic [DB_W-1:0] db_idx_t;
    typedef logic [UNIT_W-1:0] unit_idx_t;

    typedef struct packed {
        logic [N_UNITS-1:0][GRP_W-1:0] alarm;
        logic [N_UNITS-1:0] offline;
        logic [N_UNITS-1:0] relay;
    } field_in_t;

    typedef struct packed {
        logic valid;
        db_idx_t db;
        unit_idx_t unit;
        logic [GRP_W-1:0] data;
    } cmd_t;

    typedef struct packed {
        logic [GRP_W-1:0] latch;
        logic [GRP_W-1:0] readm;
        logic [GRP_W-1:0] accm;
    } latch_t;

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [REGION_W-1:0] adr_region(input logic [ADR_W-1:0] adr);
        return adr[ADR_W-1:ADR_REGION_LO];
    endfunction

    function automatic db_idx_t adr_db(input logic [ADR_W-1:0] adr);
        return adr[ADR_REGION_LO-1:ADR_DB_LO];
    endfunction

    function automatic logic [IDX_W-1:0] adr_idx(input logic [ADR_W-1:0] adr);
        return adr[ADR_DB_LO-1:ADR_IDX_LO];
    endfunction

    // Latch with read marker and accept marker; a source set of the latch always beats a clear
    function automatic latch_t latch_step(input latch_t cur, input logic [GRP_W-1:0] src,
                                          input logic [GRP_W-1:0] seen, input logic accept);
        latch_t nxt;
        logic [GRP_W-1:0] clr;
        clr = cur.latch & cur.accm & ~src;                                   // [RULE9]
        nxt.latch = (cur.latch & ~clr) | src;                                // [RULE8]
        nxt.readm = (accept ? '0 : (cur.readm | (seen & cur.latch))) & ~clr; // [RULE21]
        nxt.accm = (accept ? (cur.accm | cur.readm) : cur.accm) & ~clr;      // [RULE10]
        return nxt;
    endfunction

endpackage

// [output_value_conv.sv]
`timescale 1ns/1ps
module output_value_conv (
    // Bus side
    input wire logic [15:0] wr_data,
    input wire logic is_coil,
    input wire logic alt_variant,
    // Loop side
    input wire logic [15:0] loop_in,
    output logic [15:0] loop_out,
    output logic [15:0] readback
);
    import alarm_latch_pkg::*;

    logic [15:0] limit;
    logic [15:0] value;
    logic [15:0] clamped;

    always_comb begin
        limit = alt_variant ? HOLD_MAX_ALT : HOLD_MAX_GENERIC;
        // Coil on drives the full-scale value so a pulse output acts
        if (is_coil) begin
            value = (wr_data == COIL_OFF) ? COIL_OFF : limit; // [RULE3]
        end else begin
            value = wr_data;
        end
        // Negative values carry no meaning for an actuator output
        if (value[15]) begin
            clamped = '0;
        end else if (value > limit) begin
            clamped = limit; // [RULE4]
        end else begin
            clamped = value;
        end
        // In the generic variant the loop carries reduced resolution; readback rebuilds from it and may lose one count
        if (alt_variant) begin
            loop_out = clamped >> LOOP_SHIFT_ALT;
            readback = 16'(loop_in << LOOP_SHIFT_ALT); // [RULE5]
        end else begin
            loop_out = clamped >> LOOP_SHIFT_GENERIC;
            readback = 16'(loop_in << LOOP_SHIFT_GENERIC); // [RULE5]
        end
    end
endmodule

// [alarm_latch_checker.sv]
`timescale 1ns/1ps
module alarm_latch_checker (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // Wishbone
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [alarm_latch_pkg::ADR_W-1:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [alarm_latch_pkg::DATA_W-1:0] WB_DAT_I,
    input wire logic [alarm_latch_pkg::DATA_W-1:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    // Loop command
    input wire alarm_latch_pkg::cmd_t LOOP_CMD
);
    import alarm_latch_pkg::*;
    logic [REGION_W-1:0] region;
    logic rd_done;
    // Write of both low bytes to a mapped unit of a real database
    logic wr_ok;
    logic [ADR_W-1:0] last_adr;
    logic [ADR_W-1:0] next_last_adr;
    assign region = WB_ADR_I[ADR_W-1:ADR_REGION_LO];
    assign rd_done = WB_CYC_I && WB_STB_I && WB_ACK_O && !WB_WE_I;
    assign wr_ok = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_SEL_I[1:0] == 2'h3
                   && WB_ADR_I[13:12] != 2'h3 && WB_ADR_I[11:2] < 10'h03C;
    always_comb begin
        next_last_adr = WB_ADR_I;
    end
    always_ff @(posedge CLK) begin
        last_adr <= next_last_adr;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    property p_ack_timing; (WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O ##1 !WB_ACK_O; endproperty
    a_ack_timing: assert property (p_ack_timing) else $error("ack not a one-cycle answer");
    property p_hold_limit; rd_done && region == REG_HOLD |-> WB_DAT_O <= {16'h0000, HOLD_MAX_GENERIC}; endproperty
    a_hold_limit: assert property (p_hold_limit) else $error("holding readback out of range");
    property p_disc_bit; rd_done && region == REG_DISC |-> WB_DAT_O[31:1] == 31'h0; endproperty
    a_disc_bit: assert property (p_disc_bit) else $error("discrete read wider than one bit");
    property p_ustat_bits; rd_done && region == REG_USTAT |-> WB_DAT_O[31:3] == 29'h0; endproperty
    a_ustat_bits: assert property (p_ustat_bits) else $error("unit status has stray bits");
    property p_status_bits;
        rd_done && region == REG_STATION && WB_ADR_I[11:2] == IDX_STATUS |-> WB_DAT_O[31:4] == 28'h0
            && WB_DAT_O[1:0] == 2'h0;
    endproperty
    a_status_bits: assert property (p_status_bits) else $error("station status has stray bits");
    property p_db3_empty; rd_done && WB_ADR_I[13:12] == 2'h3 |-> WB_DAT_O == 32'h0; endproperty
    a_db3_empty: assert property (p_db3_empty) else $error("unused database returned data");
    property p_cmd_cause;
        wr_ok && region == REG_HOLD |=> LOOP_CMD.valid && LOOP_CMD.db == last_adr[13:12]
            && LOOP_CMD.unit == last_adr[7:2] && LOOP_CMD.data <= HOLD_MAX_GENERIC;
    endproperty
    a_cmd_cause: assert property (p_cmd_cause) else $error("holding write sent no matching command");
    property p_coil_off; wr_ok && region == REG_COIL && WB_DAT_I[15:0] == COIL_OFF |=> LOOP_CMD.valid
        && LOOP_CMD.data == 16'h0000; endproperty
    a_coil_off: assert property (p_coil_off) else $error("coil off not sent as zero");
    property p_cmd_only; LOOP_CMD.valid |-> $past(WB_ACK_O) && $past(WB_WE_I); endproperty
    a_cmd_only: assert property (p_cmd_only) else $error("command without a write");
endmodule

bind alarm_latch_accept_unit alarm_latch_checker chk_u (.CLK(CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .LOOP_CMD(LOOP_CMD));

// [wb_host_model.sv]
`timescale 1ns/1ps
module wb_host_model (
    // Clock
    input wire logic clk,
    // Wishbone master
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [alarm_latch_pkg::ADR_W-1:0] adr,
    output logic [3:0] sel,
    output logic [alarm_latch_pkg::DATA_W-1:0] dat,
    input wire logic ack,
    // Request still waiting for its answer
    output logic stalled
);
    import alarm_latch_pkg::*;
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = '0;
        sel = 4'h0;
        dat = '0;
        stalled = 1'b0;
    end
    // Raw zero-based address goes on the bus, no host-side offset
    task automatic xfer(input logic w, input logic [ADR_W-1:0] a, input logic [15:0] d, input logic [3:0] s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        dat <= {16'h0000, d};
        stalled <= 1'b1;
        // Only the bench watchdog ends a wait that never gets its answer
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        stalled <= 1'b0;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        // Slow host now and then
        repeat ($urandom_range(1)) @(posedge clk);
    endtask
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top;
    import alarm_latch_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc, stb, we, ack, stalled;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [DATA_W-1:0] dat_w, dat_r;
    field_in_t field = '0;
    cmd_t loop_cmd;
    int num_errors = 0;
    int check_count = 0;
    logic [DATA_W-1:0] exp_rd[$];
    logic [23:0] exp_cmd[$];
    always #25 clk = ~clk;
    wb_host_model host_u (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(dat_w),
        .ack(ack), .stalled(stalled));
    alarm_latch_accept_unit dut_u (.CLK(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_w), .WB_DAT_O(dat_r), .WB_ACK_O(ack),
        .FIELD_IN(field), .LOOP_CMD(loop_cmd));
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [ADR_W-1:0] ad(input logic [REGION_W-1:0] r, input logic [1:0] d, input int i);
        return {r, d, i[9:0], 2'h0};
    endfunction
    task automatic rd(input logic [ADR_W-1:0] a, input logic [DATA_W-1:0] e);
        exp_rd.push_back(e);
        host_u.xfer(1'b0, a, 16'h0000, 4'hF);
    endtask
    task automatic wr(input logic [ADR_W-1:0] a, input logic [15:0] d);
        host_u.xfer(1'b1, a, d, 4'hF);
    endtask
    task automatic wc(input logic [ADR_W-1:0] a, input logic [15:0] d, input logic [15:0] e);
        exp_cmd.push_back({a[13:12], a[7:2], e});
        wr(a, d);
    endtask
    task automatic accept(input logic [1:0] d);
        wr(ad(REG_STATION, d, IDX_ACCEPT), 16'h0000);
    endtask
    // Source levels are held long enough to pass the input synchroniser
    task automatic set_field(input int u, input logic [15:0] a, input logic off, input logic rel);
        @(posedge clk);
        field.alarm[u] <= a;
        field.offline[u] <= off;
        field.relay[u] <= rel;
        repeat (3) @(posedge clk);
    endtask
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ****************************************
    // Monitor: oldest expectation against each answer
    // ****************************************
    // Pop once into a variable; the check macro names its expected value twice
    logic [DATA_W-1:0] exp_r;
    logic [23:0] exp_c;
    always @(posedge clk) begin
        if (rst_n && ack === 1'b1 && we === 1'b0) begin
            if (exp_rd.size() == 0) `CHK(1'b1, 1'b0)
            else begin
                exp_r = exp_rd.pop_front();
                `CHK(dat_r, exp_r)
            end
        end
        if (loop_cmd.valid === 1'b1) begin
            if (exp_cmd.size() == 0) `CHK(1'b1, 1'b0)
            else begin
                exp_c = exp_cmd.pop_front();
                `CHK({loop_cmd.db, loop_cmd.unit, loop_cmd.data}, exp_c)
            end
        end
    end
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        logic [15:0] r;
        logic [15:0] v;
        int k;
        logic [15:0] coil[3];
        void'($urandom(67));
        r = 16'($urandom_range(16'hFFFF, 1));
        v = 16'($urandom);
        k = $urandom_range(15);
        coil = '{16'h0000, 16'hFF00, r};
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(ad(REG_STATION, 2'h0, IDX_CTRL), 32'h0);
        rd(ad(REG_STATION, 2'h0, IDX_STATUS), 32'h0);
        rd(ad(4'h9, 2'h0, 0), 32'h0);
        rd(ad(REG_ALARM, 2'h3, 5), 32'h0);
        rd(ad(REG_ALARM, 2'h0, 60), 32'h0);
        wr(ad(REG_STATION, 2'h1, IDX_LOOPBACK), v);
        host_u.xfer(1'b1, ad(REG_STATION, 2'h1, IDX_LOOPBACK), ~v, 4'h1);
        rd(ad(REG_STATION, 2'h1, IDX_LOOPBACK), {16'h0000, v});
        // Transient alarm on unit 5, read in the scan order a host would use
        set_field(5, r, 1'b0, 1'b0);
        set_field(5, 16'h0000, 1'b0, 1'b0);
        accept(2'h2);
        rd(ad(REG_USTAT, 2'h0, 5), 32'h3);
        rd(ad(REG_ALARM, 2'h0, 5), {16'h0000, r});
        rd(ad(REG_ALARM, 2'h2, 5), {16'h0000, r});
        accept(2'h0);
        rd(ad(REG_ALARM, 2'h0, 5), 32'h0);
        rd(ad(REG_USTAT, 2'h0, 5), 32'h0);
        rd(ad(REG_ALARM, 2'h1, 5), {16'h0000, r});
        wr(ad(REG_STATION, 2'h0, IDX_CTRL), 16'h0001);
        rd(ad(REG_ALARM, 2'h1, 5), {16'h0000, r});
        accept(2'h0);
        rd(ad(REG_ALARM, 2'h1, 5), 32'h0);
        rd(ad(REG_ALARM, 2'h2, 5), {16'h0000, r});
        accept(2'h2);
        rd(ad(REG_ALARM, 2'h2, 5), 32'h0);
        // Standing alarm on unit 7 with its monitor relay
        set_field(7, 16'h0001 << k, 1'b0, 1'b1);
        rd(ad(REG_STATION, 2'h0, IDX_STATUS), 32'hC);
        rd(ad(REG_DISC, 2'h0, 16 * 7 + k), 32'h1);
        rd(ad(REG_DISC, 2'h0, 16 * 7 + (k ^ 1)), 32'h0);
        rd(ad(REG_USTAT, 2'h0, 7), 32'h7);
        accept(2'h0);
        rd(ad(REG_ALARM, 2'h0, 7), 32'h1 << k);
        rd(ad(REG_USTAT, 2'h0, 7), 32'h5);
        set_field(7, 16'h0000, 1'b0, 1'b0);
        rd(ad(REG_ALARM, 2'h0, 7), 32'h0);
        rd(ad(REG_USTAT, 2'h0, 7), 32'h0);
        set_field(11, 16'h0000, 1'b1, 1'b0);
        rd(ad(REG_STATION, 2'h0, IDX_STATUS), 32'h4);
        set_field(11, 16'h0000, 1'b0, 1'b0);
        // Holding and coil writes toward the loop
        wc(ad(REG_HOLD, 2'h0, 12), v & 16'h7FFF, (v & 16'h7FFF) >> 1);
        rd(ad(REG_HOLD, 2'h0, 12), {16'h0000, v & 16'h7FFE});
        wc(ad(REG_HOLD, 2'h0, 13), 16'h8001, 16'h0000);
        wr(ad(REG_STATION, 2'h0, IDX_CTRL), 16'h0002);
        wc(ad(REG_HOLD, 2'h1, 20), 16'h1234, HOLD_MAX_ALT);
        rd(ad(REG_HOLD, 2'h1, 20), {16'h0000, HOLD_MAX_ALT});
        foreach (coil[i]) begin
            wc(ad(REG_COIL, 2'h2, 30), coil[i], (coil[i] == 16'h0000) ? 16'h0000 : HOLD_MAX_ALT);
            rd(ad(REG_COIL, 2'h2, 30), (coil[i] == 16'h0000) ? 32'h0 : {16'h0000, HOLD_MAX_ALT});
        end
        repeat (4) @(posedge clk);
        `CHK(exp_rd.size() + exp_cmd.size(), 0)
        `CHK(stalled, 1'b0)
        print_verdict();
    end
endmodule
